/* File: hdl/rre_exec.sv */
// Our own choices: the register addresses and strobed register access.
`timescale 1ns/100ps
module rre_exec
    import rre_pkg::*;
(
    input wire logic clock_in,             // Quarter-cycle clock
    input wire logic sys_rst_in,           // Async reset
    input wire logic [15:0] opcode_in,     // Fetched instruction
    input wire logic opcode_valid_in,      // Opcode present at Q1
    input wire logic ext_set_in,           // Extended set enabled
    input wire logic irq_high_active_in,   // Returning from high level
    input wire logic [7:0] file_data_in,   // File read data
    input wire logic push_in,              // Call pushes return addr
    input wire logic [20:0] push_data_in,  // Return address
    output logic [20:0] pc_out,            // Program counter
    output logic [7:0] accumulator_out,    // Working register
    output logic [7:0] status_out,         // Status flags
    output logic [7:0] bank_select_latch_out, // Bank select
    output logic [7:0] pc_high_latch_out,  // Unchanged latch
    output logic [7:0] pc_upper_latch_out, // Unchanged latch
    output logic high_priority_irq_enable_out, // Global/high enable
    output logic low_priority_irq_enable_out,  // Periph/low enable
    output logic [11:0] file_addr_out,     // File address
    output logic file_we_out,              // File write strobe
    output logic [7:0] file_wdata_out,     // File write data
    output logic indexed_mode_out,         // Indexed offset mode
    output logic busy_out                  // Second cycle in progress
);
    ////////////////////////////////////////////////////////////////////////
    rre_state_t state_reg, state_next;
    logic [1:0] q_reg, q_next;
    logic [15:0] op_reg, op_next;
    logic [20:0] pc_reg, pc_next;
    logic [7:0] acc_reg, acc_next, stat_reg, stat_next, bsr_reg, bsr_next;
    logic [7:0] acc_sh_reg, stat_sh_reg, bsr_sh_reg;
    logic high_priority_irq_enable_reg, high_priority_irq_enable_next, low_priority_irq_enable_reg, low_priority_irq_enable_next;
    logic [11:0] fa_reg, fa_next;
    logic fwe_reg, fwe_next, idx_reg, idx_next;
    logic [7:0] fwd_reg, fwd_next;
    logic pop, is_irq, is_sub, is_lit, is_rot;
    logic [20:0] top_of_stack;
    logic [7:0] rot_res;
    logic rot_c, rot_n, rot_z;

    rre_stack u_stack (
        .clock_in(clock_in),
        .sys_rst_in(sys_rst_in),
        .push_in(push_in),
        .push_data_in(push_data_in),
        .pop_in(pop),
        .top_out(top_of_stack),
        .depth_out()
    );
    rre_rotate u_rot (
        .operand_in(file_data_in),
        .carry_in(stat_reg[RRE_C_BIT]),
        .result_out(rot_res),
        .carry_out(rot_c),
        .neg_out(rot_n),
        .zero_out(rot_z)
    );

    ////////////////////////////////////////////////////////////////////////
    // Decode of the latched opcode
    always_comb begin
        is_irq = (op_reg[15:1] == RRE_OP_RETIRQ);
        is_sub = (op_reg[15:1] == RRE_OP_RETSUB);
        is_lit = (op_reg[15:8] == RRE_OP_RETLIT);
        is_rot = (op_reg[15:10] == RRE_OP_ROTC);
        pop = (state_reg == RRE_EXEC) && (q_reg == RRE_Q4)
            && (is_irq || is_sub || is_lit);
    end

    always_comb begin
        state_next = state_reg;
        q_next = q_reg + 2'h1;
        op_next = op_reg;
        pc_next = pc_reg;
        acc_next = acc_reg;
        stat_next = stat_reg;
        bsr_next = bsr_reg;
        high_priority_irq_enable_next = high_priority_irq_enable_reg;
        low_priority_irq_enable_next = low_priority_irq_enable_reg;
        fa_next = fa_reg;
        fwe_next = 1'b0;
        fwd_next = fwd_reg;
        idx_next = idx_reg;
        unique case (state_reg)
            RRE_IDLE: begin
                if (q_reg == 2'h0 && opcode_valid_in) begin
                    op_next = opcode_in;
                    state_next = RRE_EXEC;
                end
            end
            RRE_EXEC: begin
                if (q_reg == 2'h1 && is_rot) begin
                    // Bank and addressing mode for the operand read
                    idx_next = ext_set_in && !op_reg[RRE_BANK_BIT]
                        && (op_reg[7:0] <= RRE_IDX_LIMIT);
                    fa_next = op_reg[RRE_BANK_BIT]
                        ? {bsr_reg[3:0], op_reg[7:0]}
                        : {4'h0, op_reg[7:0]};
                end
                if (q_reg == RRE_Q4) begin
                    state_next = RRE_IDLE;
                    if (is_irq || is_sub || is_lit) begin
                        pc_next = top_of_stack;
                        state_next = RRE_NOP2;
                    end
                    if (is_irq) begin
                        // PC latches untouched here; flags and bank select change only by the shadow restore when bit 0 is set
                        if (irq_high_active_in) high_priority_irq_enable_next = 1'b1;
                        else low_priority_irq_enable_next = 1'b1;
                    end
                    if ((is_irq || is_sub) && op_reg[RRE_SEL_BIT]) begin
                        acc_next = acc_sh_reg;
                        stat_next = stat_sh_reg;
                        bsr_next = bsr_sh_reg;
                    end
                    if (is_lit) acc_next = op_reg[7:0];
                    if (is_rot) begin
                        stat_next[RRE_C_BIT] = rot_c;
                        stat_next[RRE_N_BIT] = rot_n;
                        stat_next[RRE_Z_BIT] = rot_z;
                        if (op_reg[RRE_DEST_BIT]) begin
                            fwe_next = 1'b1;
                            fwd_next = rot_res;
                        end else begin
                            acc_next = rot_res;
                        end
                    end
                end
            end
            RRE_NOP2: begin
                if (q_reg == RRE_Q4) state_next = RRE_IDLE;
            end
            default: state_next = RRE_IDLE;
        endcase
    end

    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            state_reg <= RRE_IDLE;
            q_reg <= 2'h0;
            op_reg <= 16'h0000;
            pc_reg <= RRE_PC_RST;
            acc_reg <= RRE_BYTE_RST;
            stat_reg <= RRE_BYTE_RST;
            bsr_reg <= RRE_BYTE_RST;
            high_priority_irq_enable_reg <= 1'b0;
            low_priority_irq_enable_reg <= 1'b0;
            fa_reg <= 12'h000;
            fwe_reg <= 1'b0;
            fwd_reg <= RRE_BYTE_RST;
            idx_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            q_reg <= q_next;
            op_reg <= op_next;
            pc_reg <= pc_next;
            acc_reg <= acc_next;
            stat_reg <= stat_next;
            bsr_reg <= bsr_next;
            high_priority_irq_enable_reg <= high_priority_irq_enable_next;
            low_priority_irq_enable_reg <= low_priority_irq_enable_next;
            fa_reg <= fa_next;
            fwe_reg <= fwe_next;
            fwd_reg <= fwd_next;
            idx_reg <= idx_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Shadows capture on push; the interrupt entry path is outside
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            acc_sh_reg <= RRE_BYTE_RST;
            stat_sh_reg <= RRE_BYTE_RST;
            bsr_sh_reg <= RRE_BYTE_RST;
        end else if (push_in) begin
            acc_sh_reg <= acc_reg;
            stat_sh_reg <= stat_reg;
            bsr_sh_reg <= bsr_reg;
        end
    end

    always_comb begin
        pc_out = pc_reg;
        accumulator_out = acc_reg;
        status_out = stat_reg;
        bank_select_latch_out = bsr_reg;
        pc_high_latch_out = RRE_BYTE_RST;
        pc_upper_latch_out = RRE_BYTE_RST;
        high_priority_irq_enable_out = high_priority_irq_enable_reg;
        low_priority_irq_enable_out = low_priority_irq_enable_reg;
        file_addr_out = fa_reg;
        file_we_out = fwe_reg;
        file_wdata_out = fwd_reg;
        indexed_mode_out = idx_reg;
        busy_out = (state_reg == RRE_NOP2);
    end

    ////////////////////////////////////////////////////////////////////////
    sequence ret_q4_s;
        state_reg == RRE_EXEC && q_reg == RRE_Q4
            && (is_irq || is_sub || is_lit);
    endsequence
    ret_pc_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        ret_q4_s |=> pc_reg == $past(top_of_stack))
        else $error("return did not load top of stack");
    ret_two_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        ret_q4_s |=> (state_reg == RRE_NOP2) [*4])
        else $error("return second cycle missing");
    irq_en_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        ret_q4_s ##0 is_irq |=> high_priority_irq_enable_reg || low_priority_irq_enable_reg)
        else $error("interrupt enable not set");
    irq_flags_a: assert property (@(posedge clock_in)
        disable iff (sys_rst_in) ret_q4_s ##0 is_irq
        && !op_reg[0] |=> $stable(stat_reg))
        else $error("interrupt return altered flags");
    shadow_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        ret_q4_s ##0 !is_lit && op_reg[0] |=> acc_reg == $past(acc_sh_reg))
        else $error("shadow restore failed");
    lit_acc_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        ret_q4_s ##0 is_lit |=> acc_reg == $past(op_reg[7:0]))
        else $error("literal not written");
    rot_z_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        state_reg == RRE_EXEC && q_reg == RRE_Q4 && is_rot
        |=> stat_reg[RRE_Z_BIT] == ($past(rot_res) == 8'h00))
        else $error("rotate zero flag wrong");
    rot_dst_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        state_reg == RRE_EXEC && q_reg == RRE_Q4 && is_rot
        |=> file_we_out == $past(op_reg[RRE_DEST_BIT]))
        else $error("rotate destination wrong");
endmodule : rre_exec

/* File: hdl/rre_pkg.sv */
package rre_pkg;
    // Opcode patterns
    localparam logic [14:0] RRE_OP_RETIRQ = 15'h0008; // 0000 0000 0001 000
    localparam logic [14:0] RRE_OP_RETSUB = 15'h0009; // 0000 0000 0001 001
    localparam logic [7:0] RRE_OP_RETLIT = 8'h0C;     // 0000 1100
    localparam logic [5:0] RRE_OP_ROTC = 6'h0D;       // 0011 01
    // Field positions
    localparam int RRE_SEL_BIT = 0;
    localparam int RRE_DEST_BIT = 9;
    localparam int RRE_BANK_BIT = 8;
    // Indexed literal offset limit
    localparam logic [7:0] RRE_IDX_LIMIT = 8'h5F;
    // Status bit positions
    localparam int RRE_C_BIT = 0;
    localparam int RRE_Z_BIT = 2;
    localparam int RRE_N_BIT = 4;
    // Quarter-cycle index of Q4, the last of an instruction cycle
    localparam logic [1:0] RRE_Q4 = 2'h3;
    // Stack geometry
    localparam int RRE_STACK_DEPTH = 31;
    localparam int RRE_PC_W = 21;
    // Reset values
    localparam logic [7:0] RRE_BYTE_RST = 8'h00;
    localparam logic [20:0] RRE_PC_RST = 21'h00_0000;
    typedef enum logic [2:0] {
        RRE_IDLE = 3'b001,
        RRE_EXEC = 3'b010,
        RRE_NOP2 = 3'b100
    } rre_state_t;
endpackage : rre_pkg

/* File: hdl/rre_rotate.sv */
`timescale 1ns/100ps
// Rotate left through carry, combinational
module rre_rotate
    import rre_pkg::*;
(
    input wire logic [7:0] operand_in, // Operand byte
    input wire logic carry_in,         // Previous carry
    output logic [7:0] result_out,     // Rotated result
    output logic carry_out,            // New carry
    output logic neg_out,              // Negative flag
    output logic zero_out              // Zero flag
);
    always_comb begin
        result_out = {operand_in[6:0], carry_in};
        carry_out = operand_in[7];
        neg_out = result_out[7];
        zero_out = (result_out == 8'h00);
    end
endmodule : rre_rotate

/* File: hdl/rre_stack.sv */
`timescale 1ns/100ps
// Return stack: pop wins over push unless the stack is empty; pointer reads the entry below
module rre_stack
    import rre_pkg::*;
(
    input wire logic clock_in,              // Core clock
    input wire logic sys_rst_in,            // Async reset
    input wire logic push_in,               // Push strobe
    input wire logic [20:0] push_data_in,   // Value pushed
    input wire logic pop_in,                // Pop strobe
    output logic [20:0] top_out,            // Top of stack
    output logic [4:0] depth_out            // Entries held
);
    logic [20:0] mem_reg [RRE_STACK_DEPTH];
    logic [20:0] mem_next [RRE_STACK_DEPTH];
    logic [4:0] ptr_reg, ptr_next;
    always_comb begin
        mem_next = mem_reg;
        ptr_next = ptr_reg;
        if (pop_in && ptr_reg != 5'h00) begin
            ptr_next = ptr_reg - 5'h01;
        end else if (push_in && ptr_reg != 5'(RRE_STACK_DEPTH)) begin
            mem_next[ptr_reg] = push_data_in;
            ptr_next = ptr_reg + 5'h01;
        end
    end
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            ptr_reg <= 5'h00;
            for (int i = 0; i < RRE_STACK_DEPTH; i++) begin
                mem_reg[i] <= RRE_PC_RST;
            end
        end else begin
            ptr_reg <= ptr_next;
            mem_reg <= mem_next;
        end
    end
    // Empty stack reads zero
    assign top_out = (ptr_reg == 5'h00) ? RRE_PC_RST : mem_reg[ptr_reg - 5'h01];
    assign depth_out = ptr_reg;
endmodule : rre_stack

/* File: sim/tb.sv */
`timescale 1ns/100ps
module tb;
    import rre_pkg::*;
    typedef struct packed {
        logic [15:0] op;
        logic [7:0] fd;
        logic ext;
        logic [7:0] res;
        logic c;
    } rre_row_t;
    logic clock_in, sys_rst_in, opcode_valid_in, ext_set_in;
    logic irq_high_active_in, push_in;
    logic [15:0] opcode_in;
    logic [7:0] file_data_in;
    logic [20:0] push_data_in, pc_out, exp_pc;
    logic [7:0] accumulator_out, status_out, bank_select_latch_out;
    logic [7:0] pc_high_latch_out, pc_upper_latch_out, file_wdata_out;
    logic [7:0] exp_acc, exp_st, exp_wd;
    logic high_priority_irq_enable_out, low_priority_irq_enable_out;
    logic [11:0] file_addr_out;
    logic file_we_out, indexed_mode_out, busy_out, exp_hi, exp_lo;
    int fails, checks_done;
    // Carry chains from row to row, starting clear after reset
    rre_row_t rows [5] = '{
        '{16'h3410, 8'hE6, 1'b0, 8'hCC, 1'b1},
        '{16'h365F, 8'h80, 1'b1, 8'h01, 1'b1},
        '{16'h3460, 8'h00, 1'b1, 8'h01, 1'b0},
        '{16'h3720, 8'h00, 1'b1, 8'h00, 1'b0},
        '{16'h3400, 8'h7F, 1'b1, 8'hFE, 1'b0}};

    rre_exec dut_u (
        .clock_in(clock_in),
        .sys_rst_in(sys_rst_in),
        .opcode_in(opcode_in),
        .opcode_valid_in(opcode_valid_in),
        .ext_set_in(ext_set_in),
        .irq_high_active_in(irq_high_active_in),
        .file_data_in(file_data_in),
        .push_in(push_in),
        .push_data_in(push_data_in),
        .pc_out(pc_out),
        .accumulator_out(accumulator_out),
        .status_out(status_out),
        .bank_select_latch_out(bank_select_latch_out),
        .pc_high_latch_out(pc_high_latch_out),
        .pc_upper_latch_out(pc_upper_latch_out),
        .high_priority_irq_enable_out(high_priority_irq_enable_out),
        .low_priority_irq_enable_out(low_priority_irq_enable_out),
        .file_addr_out(file_addr_out),
        .file_we_out(file_we_out),
        .file_wdata_out(file_wdata_out),
        .indexed_mode_out(indexed_mode_out),
        .busy_out(busy_out)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: %s got %h expected %h", $time, what,
                     got, exp);
        end
    endtask : chk

    task automatic stop_test;
        if (fails == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : stop_test

    // Entered on the edge before a Q1 edge; always spends 8 edges
    task automatic run(input logic [15:0] op, input logic [7:0] fd,
                       input logic ext, input logic hold);
        logic rot, ret;
        rot = (op[15:10] == 6'b001101);
        ret = (op[15:1] == 15'h0008) || (op[15:1] == 15'h0009) ||
              (op[15:8] == 8'h0C);
        opcode_in <= op;
        opcode_valid_in <= 1'b1;
        file_data_in <= fd;
        ext_set_in <= ext;
        @(posedge clock_in);
        opcode_valid_in <= 1'b0;
        repeat (3) @(posedge clock_in);
        // Offer a literal return in the busy cycle; it must be ignored
        if (hold) begin
            opcode_in <= 16'h0C11;
            opcode_valid_in <= 1'b1;
        end
        #1;
        chk(pc_out, exp_pc, "pc");
        chk(accumulator_out, exp_acc, "acc");
        chk(status_out, exp_st, "status");
        chk({high_priority_irq_enable_out, low_priority_irq_enable_out},
            {exp_hi, exp_lo}, "enables");
        chk({bank_select_latch_out, pc_upper_latch_out, pc_high_latch_out},
            24'h00_0000, "latches");
        chk(file_we_out, rot && op[9], "we");
        if (rot) begin
            chk(indexed_mode_out, ext && !op[8] && (op[7:0] <= 8'h5F),
                "indexed");
            chk(file_addr_out[7:0], op[7:0], "addr");
            if (op[8]) chk(file_addr_out[11:8], 4'h0, "bank");
            if (op[9]) chk(file_wdata_out, exp_wd, "wdata");
        end
        @(posedge clock_in);
        #1;
        chk(busy_out, ret, "busy");
        repeat (2) @(posedge clock_in);
        opcode_valid_in <= 1'b0;
        @(posedge clock_in);
    endtask : run

    // Two pushes back to back; spends 4 edges
    task automatic push2(input logic [20:0] a, input logic [20:0] b);
        push_in <= 1'b1;
        push_data_in <= a;
        @(posedge clock_in);
        push_data_in <= b;
        @(posedge clock_in);
        push_in <= 1'b0;
        repeat (2) @(posedge clock_in);
    endtask : push2

    ////////////////////////////////////////////////////////////////////////
    initial begin
        clock_in = 1'b0;
        forever #5 clock_in = ~clock_in;
    end

    initial begin
        fails = 0;
        checks_done = 0;
        sys_rst_in = 1'b1;
        opcode_valid_in = 1'b0;
        opcode_in = 16'h0000;
        ext_set_in = 1'b0;
        irq_high_active_in = 1'b0;
        file_data_in = 8'h00;
        push_in = 1'b0;
        push_data_in = 21'h0_0000;
        exp_pc = 21'h0_0000;
        exp_acc = 8'h00;
        exp_st = 8'h00;
        exp_wd = 8'h00;
        exp_hi = 1'b0;
        exp_lo = 1'b0;
        repeat (15) @(posedge clock_in);
        #1;
        chk({pc_out, accumulator_out, status_out}, 37'h0, "reset");
        @(posedge clock_in);
        sys_rst_in <= 1'b0;
        foreach (rows[i]) begin
            exp_wd = rows[i].res;
            if (!rows[i].op[9]) exp_acc = rows[i].res;
            exp_st = {3'b000, rows[i].res[7], 1'b0, rows[i].res == 8'h00,
                      1'b0, rows[i].c};
            run(rows[i].op, rows[i].fd, rows[i].ext, 1'b0);
        end
        // Empty stack pops zero
        exp_acc = 8'hA5;
        run(16'h0CA5, 8'h00, 1'b0, 1'b0);
        push2(21'h1_2345, 21'h0_0ABC);
        exp_pc = 21'h0_0ABC;
        exp_acc = 8'h3C;
        run(16'h0C3C, 8'h00, 1'b0, 1'b0);
        exp_pc = 21'h1_2345;
        run(16'h0012, 8'h00, 1'b0, 1'b0);
        push2(21'h1F_FFFE, 21'h0_4444);
        exp_acc = 8'h00;
        exp_st = 8'h04;
        run(16'h3400, 8'h00, 1'b0, 1'b0);
        irq_high_active_in <= 1'b1;
        exp_pc = 21'h0_4444;
        exp_acc = 8'h3C;
        exp_st = 8'h10;
        exp_hi = 1'b1;
        run(16'h0011, 8'h00, 1'b0, 1'b0);
        irq_high_active_in <= 1'b0;
        exp_pc = 21'h1F_FFFE;
        exp_lo = 1'b1;
        run(16'h0010, 8'h00, 1'b0, 1'b0);
        push2(21'h0_0100, 21'h0_0200);
        exp_acc = 8'h02;
        exp_st = 8'h01;
        run(16'h3400, 8'h81, 1'b0, 1'b0);
        exp_pc = 21'h0_0200;
        exp_acc = 8'h3C;
        exp_st = 8'h10;
        run(16'h0013, 8'h00, 1'b0, 1'b0);
        exp_pc = 21'h0_0100;
        exp_acc = 8'h99;
        run(16'h0C99, 8'h00, 1'b0, 1'b1);
        // Offered opcode must not have landed; unknown opcode does nothing
        run(16'h0000, 8'h00, 1'b0, 1'b0);
        sys_rst_in <= 1'b1;
        @(posedge clock_in);
        #1;
        chk({pc_out, accumulator_out, status_out,
             high_priority_irq_enable_out}, 38'h0, "mid reset");
        stop_test();
    end
endmodule : tb
